/* logic/rclk2_pkg.sv */
// Constants and types shared by the recovered clock 2 control logic
package rclk2_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET = 8'h18;
	localparam logic [7:0] STATUS_OFFSET = 8'h1c;
	localparam int REG_W = 16;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'hff37;

	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int EN_BIT = 15;
	localparam int SRC_HI = 14;
	localparam int SRC_LO = 11;
	localparam int FREQ_HI = 10;
	localparam int FREQ_LO = 8;
	localparam int SQ_HI = 5;
	localparam int SQ_LO = 4;
	localparam int ORG_HI = 2;
	localparam int ORG_LO = 0;

	// ------------------------------------------------------------
	// Status field positions
	// ------------------------------------------------------------
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_RSVD_BIT = 1;
	localparam int ST_EXT_BIT = 2;
	localparam int ST_SQ_BIT = 3;

	// ------------------------------------------------------------
	// Field codes
	// ------------------------------------------------------------
	localparam logic [3:0] SRC_PORT0 = 4'h0;
	localparam logic [3:0] SRC_PORT1 = 4'h1;
	localparam logic [2:0] FREQ_25 = 3'h0;
	localparam logic [2:0] FREQ_125 = 3'h1;
	localparam logic [2:0] FREQ_31P25 = 3'h2;
	localparam logic [2:0] ORG_SERIAL = 3'h0;
	localparam logic [2:0] ORG_COPPER = 3'h1;

	typedef enum logic [1:0] {
		SQ_AUTO,
		SQ_RELAXED,
		SQ_LINK_ONLY,
		SQ_NEVER
	} squelch_t;

	// ------------------------------------------------------------
	// Divider, the source line clock is 125 MHz
	// ------------------------------------------------------------
	localparam int SRC_MHZ_X100 = 12500;
	localparam int DIV_25 = SRC_MHZ_X100 / 2500;
	localparam int DIV_31P25 = SRC_MHZ_X100 / 3125;
	localparam logic [2:0] DIV_CNT_25 = 3'(DIV_25 - 1);
	localparam logic [2:0] DIV_CNT_31P25 = 3'(DIV_31P25 - 1);
	localparam logic [2:0] HIGH_CNT_25 = 3'((DIV_25 + 1) / 2);
	localparam logic [2:0] HIGH_CNT_31P25 = 3'(DIV_31P25 / 2);

	// Per-port pin group: link up, stable, 1000 master, 10BASE-T,
	// EEE active, LP_IDLE seen, serial clock, copper clock
	localparam int PORTS = 2;
	localparam int PIN_PER_PORT = 8;
	localparam int PIN_W = PORTS * PIN_PER_PORT + 1;

endpackage

/* logic/pin_filter.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_filter
	import rclk2_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] pin_o
);

	// ------------------------------------------------------------
	// Synchroniser stages
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic out_r;
			wire agree = (s2_r == s3_r);
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
					out_r <= 1'b0;
				end else begin
					s1_r <= pin_i[g];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (agree) begin
						out_r <= s3_r;
					end
				end
			end
			assign pin_o[g] = out_r;
		end
	endgenerate

endmodule

/* logic/recovered_clock_out_select.sv */
// Recovered clock 2 output selection, division and squelch control
// Overview of operation
// - Output driven only while enable bit 15 is one; resets to zero.
// - Source field 14:11 picks port 0 or port 1; resets to 0000.
// - Frequency field 10:8 selects 25, 125 or 31.25 MHz; resets 000.
// - Squelch 00 holds low on bad link, master/10BASE-T or EEE.
// - Squelch 01 also runs in master/10BASE-T and EEE LP_IDLE.
// - Squelch 10 blocks output only while selected link is down.
// - Squelch 11 never squelches; clock still given with link down.
// - External squelch pin high forces output low over all fields.
// - Origin field 2:0 picks serial or copper recovered clock.
`timescale 1ns/100ps
module recovered_clock_out_select
	import rclk2_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [PORTS-1:0] link_up_i,
	input wire logic [PORTS-1:0] link_stable_i,
	input wire logic [PORTS-1:0] master_1000_i,
	input wire logic [PORTS-1:0] mode_10base_i,
	input wire logic [PORTS-1:0] eee_active_i,
	input wire logic [PORTS-1:0] lp_idle_i,
	input wire logic [PORTS-1:0] serial_rclk_i,
	input wire logic [PORTS-1:0] copper_rclk_i,
	input wire logic ext_squelch_i,
	output logic recovered_clock_out_two_o
);

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins;
	assign pins_raw = {ext_squelch_i, copper_rclk_i, serial_rclk_i,
		lp_idle_i, eee_active_i, mode_10base_i, master_1000_i,
		link_stable_i, link_up_i};

	pin_filter #(
		.W(PIN_W)
	) u_pins (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(pins_raw),
		.pin_o(pins)
	);

	wire [PORTS-1:0] s_up = pins[1:0];
	wire [PORTS-1:0] s_stable = pins[3:2];
	wire [PORTS-1:0] s_master = pins[5:4];
	wire [PORTS-1:0] s_m10 = pins[7:6];
	wire [PORTS-1:0] s_eee = pins[9:8];
	wire [PORTS-1:0] s_lpi = pins[11:10];
	wire [PORTS-1:0] s_serial = pins[13:12];
	wire [PORTS-1:0] s_copper = pins[15:14];
	wire s_ext = pins[16];

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	logic [REG_W-1:0] ctrl_r;
	logic [REG_W-1:0] status_r;
	logic ack_r;
	logic [31:0] dat_r;

	function automatic logic [15:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
	endfunction

	wire req = wb_cyc_i & wb_stb_i & ~ack_r;
	wire hit_ctrl = (wb_adr_i == CTRL_OFFSET);
	wire hit_status = (wb_adr_i == STATUS_OFFSET);
	wire [15:0] wmask = lane_mask(wb_sel_i) & CTRL_WMASK;
	wire [15:0] ctrl_nxt = (ctrl_r & ~wmask) | (wb_dat_i[15:0] & wmask);
	wire [31:0] rd_nxt = hit_ctrl ? {16'h0000, ctrl_r} :
		hit_status ? {16'h0000, status_r} : 32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req;
			if (req) begin
				dat_r <= rd_nxt;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= CTRL_RESET;
		end else if (req && wb_we_i && hit_ctrl) begin
			ctrl_r <= ctrl_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	wire f_en = ctrl_r[EN_BIT];
	wire [3:0] f_src = ctrl_r[SRC_HI:SRC_LO];
	wire [2:0] f_freq = ctrl_r[FREQ_HI:FREQ_LO];
	wire [1:0] f_sq = ctrl_r[SQ_HI:SQ_LO];
	wire [2:0] f_org = ctrl_r[ORG_HI:ORG_LO];

	wire src_ok = (f_src == SRC_PORT0) || (f_src == SRC_PORT1);
	wire freq_ok = (f_freq == FREQ_25) || (f_freq == FREQ_125) ||
		(f_freq == FREQ_31P25);
	wire org_ok = (f_org == ORG_SERIAL) || (f_org == ORG_COPPER);
	wire rsvd_code = ~(src_ok & freq_ok & org_ok);

	// ------------------------------------------------------------
	// Source and origin selection
	// ------------------------------------------------------------
	wire port = (f_src == SRC_PORT1);
	wire p_up = s_up[port];
	wire p_stable = s_stable[port];
	wire p_badmode = s_master[port] | s_m10[port];
	wire p_eee = s_eee[port];
	wire p_lpi = s_lpi[port];
	wire src_clk = (f_org == ORG_COPPER) ? s_copper[port] :
		s_serial[port];

	// ------------------------------------------------------------
	// Squelch policy
	// ------------------------------------------------------------
	logic squelch;
	always_comb begin
		case (squelch_t'(f_sq))
			SQ_AUTO: squelch = ~p_up | ~p_stable | p_badmode |
				p_eee;
			SQ_RELAXED: squelch = ~p_up | ~p_stable |
				(p_eee & ~p_lpi);
			SQ_LINK_ONLY: squelch = ~p_up;
			SQ_NEVER: squelch = 1'b0;
			default: squelch = 1'b1;
		endcase
	end

	wire gate = f_en & ~rsvd_code & ~squelch & ~s_ext;

	// ------------------------------------------------------------
	// Frequency divider on the selected line clock
	// ------------------------------------------------------------
	logic src_d_r;
	logic [2:0] cnt_r;
	wire src_rise = src_clk & ~src_d_r;
	wire [2:0] cnt_top = (f_freq == FREQ_25) ? DIV_CNT_25 :
		DIV_CNT_31P25;
	wire [2:0] cnt_high = (f_freq == FREQ_25) ? HIGH_CNT_25 :
		HIGH_CNT_31P25;
	wire [2:0] cnt_nxt = (cnt_r >= cnt_top) ? 3'h0 : cnt_r + 3'h1;
	wire div_clk = (f_freq == FREQ_125) ? src_clk :
		(cnt_r < cnt_high);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_d_r <= 1'b0;
			cnt_r <= 3'h0;
		end else begin
			src_d_r <= src_clk;
			if (src_rise) begin
				cnt_r <= cnt_nxt;
			end
		end
	end

	// ------------------------------------------------------------
	// Output and status
	// ------------------------------------------------------------
	logic out_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_r <= 1'b0;
			status_r <= 16'h0000;
		end else begin
			out_r <= gate & div_clk;
			status_r <= 16'h0000;
			status_r[ST_ACTIVE_BIT] <= gate;
			status_r[ST_RSVD_BIT] <= rsvd_code;
			status_r[ST_EXT_BIT] <= s_ext;
			status_r[ST_SQ_BIT] <= squelch;
		end
	end
	assign recovered_clock_out_two_o = out_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_disabled_low;
		@(posedge clk_i) disable iff (rst_i)
		!f_en |=> !out_r;
	endproperty
	a_disabled_low: assert property (p_disabled_low)
		else $error("output active while disabled");

	property p_ext_low;
		@(posedge clk_i) disable iff (rst_i)
		s_ext |=> !out_r;
	endproperty
	a_ext_low: assert property (p_ext_low)
		else $error("output active under external squelch");

	property p_rsvd_low;
		@(posedge clk_i) disable iff (rst_i)
		rsvd_code |=> !out_r;
	endproperty
	a_rsvd_low: assert property (p_rsvd_low)
		else $error("output active with reserved code");

	property p_auto_mode;
		@(posedge clk_i) disable iff (rst_i)
		(f_sq == 2'b00) && (p_badmode || p_eee) |=> !out_r;
	endproperty
	a_auto_mode: assert property (p_auto_mode)
		else $error("auto squelch let clock through");

	property p_relaxed;
		@(posedge clk_i) disable iff (rst_i)
		(f_sq == 2'b01) && f_en && !rsvd_code && !s_ext && p_up &&
			p_stable && p_lpi |=> status_r[ST_ACTIVE_BIT];
	endproperty
	a_relaxed: assert property (p_relaxed)
		else $error("relaxed squelch blocked clock");

	property p_link_only;
		@(posedge clk_i) disable iff (rst_i)
		(f_sq == 2'b10) && !p_up |=> !out_r;
	endproperty
	a_link_only: assert property (p_link_only)
		else $error("link-only squelch let clock through");

	property p_never;
		@(posedge clk_i) disable iff (rst_i)
		(f_sq == 2'b11) && f_en && !rsvd_code && !s_ext
			|=> status_r[ST_ACTIVE_BIT];
	endproperty
	a_never: assert property (p_never)
		else $error("squelch applied in disable mode");

	property p_pass_125;
		@(posedge clk_i) disable iff (rst_i)
		gate && (f_freq == FREQ_125) |=> out_r == $past(src_clk);
	endproperty
	a_pass_125: assert property (p_pass_125)
		else $error("125 MHz path does not follow source");

	property p_reset_ctrl;
		@(posedge clk_i)
		$past(rst_i) |-> ctrl_r == CTRL_RESET;
	endproperty
	a_reset_ctrl: assert property (p_reset_ctrl)
		else $error("control not at reset value");

	property p_rsvd_read;
		@(posedge clk_i) disable iff (rst_i)
		ack_r |-> dat_r[31:16] == 16'h0000 && (ctrl_r & ~CTRL_WMASK) == 0;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read)
		else $error("reserved bits not zero");

	property p_auto_link;
		@(posedge clk_i) disable iff (rst_i)
		(f_sq == 2'b00) && (!p_up || !p_stable) |=> !out_r;
	endproperty
	a_auto_link: assert property (p_auto_link)
		else $error("auto squelch ignored link state");

	property p_relaxed_mode;
		@(posedge clk_i) disable iff (rst_i)
		(f_sq == 2'b01) && f_en && !rsvd_code && !s_ext && p_up &&
			p_stable && !p_eee |=> status_r[ST_ACTIVE_BIT];
	endproperty
	a_relaxed_mode: assert property (p_relaxed_mode)
		else $error("relaxed squelch blocked master or 10BASE-T");

	property p_link_up;
		@(posedge clk_i) disable iff (rst_i)
		(f_sq == 2'b10) && f_en && !rsvd_code && !s_ext && p_up
			|=> status_r[ST_ACTIVE_BIT];
	endproperty
	a_link_up: assert property (p_link_up)
		else $error("link-only squelch blocked a linked port");

	property p_copper_one;
		@(posedge clk_i) disable iff (rst_i)
		gate && (f_freq == FREQ_125) && (f_src == SRC_PORT1) &&
			(f_org == ORG_COPPER) |=> out_r == $past(s_copper[1]);
	endproperty
	a_copper_one: assert property (p_copper_one)
		else $error("port 1 copper clock not selected");

	property p_serial_zero;
		@(posedge clk_i) disable iff (rst_i)
		gate && (f_freq == FREQ_125) && (f_src == SRC_PORT0) &&
			(f_org == ORG_SERIAL) |=> out_r == $past(s_serial[0]);
	endproperty
	a_serial_zero: assert property (p_serial_zero)
		else $error("port 0 serial clock not selected");

	property p_reset_out;
		@(posedge clk_i)
		$past(rst_i) |-> !out_r && !ack_r;
	endproperty
	a_reset_out: assert property (p_reset_out)
		else $error("output or ack active after reset");

endmodule

/* testbench/rclk_sink.sv */
// Timing circuit model that counts recovered clock rising edges
`timescale 1ns/100ps
module rclk_sink (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic rclk_i,
	output logic [15:0] count_o
);
	logic last_r;
	always_ff @(posedge clk_i) begin
		last_r <= rclk_i;
		if (rst_i || clear_i) begin
			count_o <= 16'h0000;
		end else if (rclk_i && !last_r) begin
			count_o <= count_o + 16'h0001;
		end
	end
endmodule

/* testbench/tb_recovered_clock_out_select.sv */
// Testbench for the recovered clock 2 output select block
`timescale 1ns/100ps
module tb_recovered_clock_out_select
	import rclk2_pkg::*;
;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic clk_i, rst_i, cyc, stb, we, clr, ack, rclk, ext;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, dat_o;
	logic [1:0] up, stab, m1000, m10, eee, idle, ser, cu;
	logic [15:0] cnt;
	int err_count, comparisons, cyc_n;
	logic [3:0] lanes = 4'h3;
	logic [9:0] tbl [7] = '{10'b1100001111, 10'b0100001000, 10'b1000001100,
		10'b1110001110, 10'b1101001110, 10'b1100101100, 10'b1100111110};

	recovered_clock_out_select dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.link_up_i(up), .link_stable_i(stab), .master_1000_i(m1000),
		.mode_10base_i(m10), .eee_active_i(eee), .lp_idle_i(idle),
		.serial_rclk_i(ser), .copper_rclk_i(cu), .ext_squelch_i(ext),
		.recovered_clock_out_two_o(rclk));
	rclk_sink sink (.clk_i(clk_i), .rst_i(rst_i), .clear_i(clr),
		.rclk_i(rclk), .count_o(cnt));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// Source clocks with half periods of 4, 5, 6 and 7 cycles
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		ser <= {1'((cyc_n / 5) % 2), 1'((cyc_n / 4) % 2)};
		cu <= {1'((cyc_n / 7) % 2), 1'((cyc_n / 6) % 2)};
	end

	// ------------------------------------------------------------
	// Bus, measurement and compare tasks
	// ------------------------------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= lanes;
		dat <= {16'h0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) err_count++;
		q = dat_o[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic check(input string nm, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic meas(input int n);
		repeat (12) @(posedge clk_i);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		repeat (n) @(posedge clk_i);
	endtask

	task automatic near(input string nm, input int e);
		check(nm, (cnt >= 16'(e - 1) && cnt <= 16'(e + 1)) ? 16'(e) : cnt,
			16'(e));
	endtask

	function automatic logic [15:0] cw(logic [3:0] s, logic [2:0] f,
		logic [1:0] q, logic [2:0] o);
		return {1'b1, s, f, 2'b00, q, 1'b0, o};
	endfunction

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		logic [15:0] q;
		xfer(1'b0, CTRL_OFFSET, 16'h0000, q);
		check("ctrl_reset", q, 16'h0000);
		up <= 2'b11;
		stab <= 2'b11;
		meas(100);
		check("out_disabled", cnt, 16'h0000);
		wr(CTRL_OFFSET, 16'hffff);
		xfer(1'b0, CTRL_OFFSET, 16'h0000, q);
		check("ctrl_rw", q, 16'hff37);
		wr(8'h40, 16'h1234);
		xfer(1'b0, 8'h40, 16'h0000, q);
		check("unmapped", q, 16'h0000);
		xfer(1'b0, CTRL_OFFSET, 16'h0000, q);
		check("ctrl_kept", q, 16'hff37);
		lanes = 4'h1;
		wr(CTRL_OFFSET, 16'h0000);
		lanes = 4'h3;
		xfer(1'b0, CTRL_OFFSET, 16'h0000, q);
		check("ctrl_lane0", q, 16'hff00);
		$display("test registers done");
	endtask

	task automatic t_select;
		for (int p = 0; p < 2; p++) begin
			for (int o = 0; o < 2; o++) begin
				wr(CTRL_OFFSET, cw(4'(p), 3'h1, 2'h3, 3'(o)));
				meas(840);
				near("src_clock", 420 / (o ? 6 + p : 4 + p));
			end
		end
		for (int f = 0; f < 3; f++) begin
			wr(CTRL_OFFSET, cw(4'h0, 3'(f), 2'h3, 3'h0));
			meas(840);
			near("freq", 105 / (f == 0 ? 5 : f == 1 ? 1 : 4));
		end
		$display("test select done");
	endtask

	task automatic t_squelch;
		for (int i = 0; i < 7; i++) begin
			for (int s = 0; s < 4; s++) begin
				up <= {1'b1, tbl[i][9]};
				stab <= {1'b1, tbl[i][8]};
				m1000 <= {1'b0, tbl[i][7]};
				m10 <= {1'b0, tbl[i][6]};
				eee <= {1'b0, tbl[i][5]};
				idle <= {1'b0, tbl[i][4]};
				wr(CTRL_OFFSET, cw(4'h0, 3'h1, 2'(s), 3'h0));
				meas(120);
				check("squelch", 16'(cnt != 0), 16'(tbl[i][s]));
			end
		end
		$display("test squelch done");
	endtask

	task automatic t_override;
		logic [15:0] bad [3] = '{16'h9130, 16'h8330, 16'h8132};
		logic [15:0] q;
		for (int i = 0; i < 3; i++) begin
			wr(CTRL_OFFSET, bad[i]);
			meas(120);
			check("reserved_code", cnt, 16'h0000);
			xfer(1'b0, STATUS_OFFSET, 16'h0000, q);
			check("status_rsvd", q, 16'(1 << ST_RSVD_BIT));
		end
		wr(CTRL_OFFSET, cw(4'h0, 3'h1, 2'h3, 3'h0));
		ext <= 1'b1;
		meas(120);
		check("ext_squelch", cnt, 16'h0000);
		xfer(1'b0, STATUS_OFFSET, 16'h0000, q);
		check("status_ext", q, 16'(1 << ST_EXT_BIT));
		wr(STATUS_OFFSET, 16'hffff);
		xfer(1'b0, STATUS_OFFSET, 16'h0000, q);
		check("status_ro", q, 16'(1 << ST_EXT_BIT));
		ext <= 1'b0;
		$display("test override done");
	endtask

	task automatic t_reset;
		logic [15:0] q;
		wr(CTRL_OFFSET, cw(4'h1, 3'h2, 2'h2, 3'h1));
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		xfer(1'b0, CTRL_OFFSET, 16'h0000, q);
		check("ctrl_after_reset", q, CTRL_RESET);
		meas(100);
		check("out_after_reset", cnt, 16'h0000);
		$display("test reset done");
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, clr, ext, adr, sel, dat} = '0;
		{up, stab, m1000, m10, eee, idle} = '0;
		{err_count, comparisons} = '0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_select;
		t_squelch;
		t_override;
		t_reset;
		wrap_up;
	end

	initial begin
		repeat (40000) @(posedge clk_i);
		err_count++;
		wrap_up;
	end
endmodule
